// *** logic/bpq_cmp_if.sv ***
// Interface carrying one comparator's settings into its match unit and the match back
`timescale 1ns/1ps
interface bpq_cmp_if;
    logic enable; // Comparator active in the current mode
    logic data_mode; // Compare data bytes instead of address
    logic page_sel; // Program page access selected for this compare
    logic [5:0] ext; // Extended compare field
    logic [7:0] high; // High compare byte
    logic [7:0] low; // Low compare byte
    logic mask_hi; // Effective high mask bit
    logic mask_lo; // Effective low mask bit
    logic dir_en; // Bus direction takes part
    logic dir_val; // 0 write, 1 read
    logic match; // Combinational match result

    // ------------------------------------------------------------
    // Configuring side and matching side
    // ------------------------------------------------------------
    modport cfg (output enable, data_mode, page_sel, ext, high, low, mask_hi, mask_lo, dir_en, dir_val,
                 input match);
    modport unit (input enable, data_mode, page_sel, ext, high, low, mask_hi, mask_lo, dir_en, dir_val,
                  output match);
endinterface : bpq_cmp_if

// *** logic/bpq_match.sv ***
// One breakpoint comparator: byte masks, page compare and direction qualifier
`timescale 1ns/1ps
module bpq_match (
    bpq_cmp_if.unit cmp,
    input wire logic [15:0] cpu_addr,
    input wire logic [15:0] cpu_data,
    input wire logic [5:0] program_page_index,
    input wire logic cpu_read,
    input wire logic cpu_valid
);
    logic hi_en; // High byte takes part
    logic lo_en; // Low byte takes part
    logic hi_ok; // High byte agrees
    logic lo_ok; // Low byte agrees
    logic ext_ok; // Page bits agree or are unused
    logic dir_ok; // Direction agrees or is unused
    logic need_page; // Only a program page access can hit

    // ------------------------------------------------------------
    // Qualification of every byte for the current bus cycle
    // ------------------------------------------------------------
    always_comb begin
        hi_en = 1'b1;
        lo_en = 1'b1;
        hi_ok = 1'b0;
        lo_ok = 1'b0;
        ext_ok = 1'b1;
        dir_ok = 1'b1;
        need_page = 1'b0;
        if (cmp.data_mode) begin
            // Data bytes: each mask bit gates its own byte, page bits never used
            hi_en = !cmp.mask_hi;
            lo_en = !cmp.mask_lo;
            hi_ok = (cmp.high == cpu_data[15:8]);
            lo_ok = (cmp.low == cpu_data[7:0]);
        end else begin
            // Low mask clear means full compare, whatever the high bit says
            lo_en = !cmp.mask_lo;
            hi_en = !(cmp.mask_hi && cmp.mask_lo);
            need_page = cmp.mask_hi && cmp.mask_lo;
            lo_ok = (cmp.low == cpu_addr[7:0]);
            if (cmp.page_sel) begin
                // Paged: six extended bits stand for address bits 19 to 14
                ext_ok = (cmp.ext == program_page_index);
                hi_ok = (cmp.high[5:0] == cpu_addr[13:8]);
            end else begin
                // Unpaged: plain 16-bit compare, extended field ignored
                hi_ok = (cmp.high == cpu_addr[15:8]);
            end
            // Direction only qualifies address compares
            dir_ok = !cmp.dir_en || (cmp.dir_val == cpu_read);
        end
        // All enabled parts must agree in the same cycle
        cmp.match = cmp.enable && cpu_valid && (hi_ok || !hi_en) && (lo_ok || !lo_en)
                    && ext_ok && dir_ok && (!need_page || cmp.page_sel);
    end
endmodule : bpq_match

// *** logic/bpq_pkg.sv ***
// Package with register map, field layout and bus constants of the breakpoint qualifier
package bpq_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [29:0] IDX_DEBUG_CONTROL_3 = 30'h00000029;
    localparam logic [29:0] IDX_CMP_A_EXTENDED = 30'h0000002A;
    localparam logic [29:0] IDX_CMP_A_HIGH = 30'h0000002B;
    localparam logic [29:0] IDX_CMP_A_LOW = 30'h0000002C;
    localparam logic [29:0] IDX_CMP_B_EXTENDED = 30'h0000002D;
    localparam logic [29:0] IDX_CMP_B_HIGH = 30'h0000002E;
    localparam logic [29:0] IDX_CMP_B_LOW = 30'h0000002F;
    localparam logic [29:0] IDX_MODE_CONTROL = 30'h00000030;
    localparam logic [29:0] IDX_MATCH_STATUS = 30'h00000031;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h00000000;

    // ------------------------------------------------------------
    // Field positions of debug_control_3
    // ------------------------------------------------------------
    localparam int unsigned C3_FIRST_MASK_HIGH = 7;
    localparam int unsigned C3_FIRST_MASK_LOW = 6;
    localparam int unsigned C3_SECOND_MASK_HIGH = 5;
    localparam int unsigned C3_SECOND_MASK_LOW = 4;
    localparam int unsigned C3_A_DIR_ENABLE = 3;
    localparam int unsigned C3_A_DIR_VALUE = 2;
    localparam int unsigned C3_B_DIR_ENABLE = 1;
    localparam int unsigned C3_B_DIR_VALUE = 0;

    // ------------------------------------------------------------
    // Extended registers: page selector and extended compare field
    // ------------------------------------------------------------
    localparam int unsigned EXT_PAGE_SELECT = 6;
    localparam int unsigned EXT_FIELD_MSB = 5;

    // ------------------------------------------------------------
    // Mode control and match status fields
    // ------------------------------------------------------------
    localparam int unsigned MODE_BREAKPOINT_ONLY = 0;
    localparam int unsigned MODE_TRACE_CAPTURE = 1;
    localparam int unsigned MODE_FULL = 2;
    localparam int unsigned STAT_HIT_A = 0;
    localparam int unsigned STAT_HIT_B = 1;
    localparam int unsigned STAT_HIT_BREAK = 2;
    localparam int unsigned STAT_LIVE_A = 4;
    localparam int unsigned STAT_LIVE_B = 5;

    // ------------------------------------------------------------
    // AHB-Lite transfer type and response
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;
endpackage : bpq_pkg

// *** logic/bpq_top.sv ***
// Breakpoint mask and direction qualifier with an AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module bpq_top (
    input wire logic ref_clk,
    input wire logic arst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // CPU bus cycle under watch
    input wire logic [15:0] cpu_addr,
    input wire logic [15:0] cpu_data,
    input wire logic [5:0] program_page_index,
    input wire logic cpu_page_access,
    input wire logic cpu_read,
    input wire logic cpu_valid,
    // Break requests to the core
    output logic break_a,
    output logic break_b,
    output logic break_req
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] debug_control_3; // Masks and direction qualifiers
    logic [7:0] cmp_a_extended; // Page select and extended field A
    logic [7:0] cmp_a_high; // Comparator A high byte
    logic [7:0] cmp_a_low; // Comparator A low byte
    logic [7:0] cmp_b_extended; // Page select and extended field B
    logic [7:0] cmp_b_high; // Comparator B high byte
    logic [7:0] cmp_b_low; // Comparator B low byte
    logic [7:0] mode_control; // Operating mode
    logic [7:0] match_status; // Sticky hits and live matches
    logic wr_pend; // Write data phase pending
    logic [29:0] wr_idx; // Index of the pending write

    // Next values
    logic [7:0] next_debug_control_3;
    logic [7:0] next_cmp_a_extended;
    logic [7:0] next_cmp_a_high;
    logic [7:0] next_cmp_a_low;
    logic [7:0] next_cmp_b_extended;
    logic [7:0] next_cmp_b_high;
    logic [7:0] next_cmp_b_low;
    logic [7:0] next_mode_control;
    logic [7:0] next_match_status;
    logic next_wr_pend;
    logic [29:0] next_wr_idx;
    logic [31:0] next_hrdata;

    // ------------------------------------------------------------
    // Match state
    // ------------------------------------------------------------
    logic next_break_a;
    logic next_break_b;
    logic next_break_req;

    // ------------------------------------------------------------
    // Derived mode, bus and match terms
    // ------------------------------------------------------------
    logic bp_on; // Breakpoint only mode active
    logic tc_on; // Trace capture mode active
    logic full_on; // Address on A, data on B
    logic addr_phase; // Valid transfer accepted this cycle
    logic [29:0] req_idx; // Word index of the request
    logic a_match; // Live match of comparator A
    logic b_match; // Live match of comparator B

    // One carrier per comparator
    bpq_cmp_if cmp_a ();
    bpq_cmp_if cmp_b ();

    // Word index of a byte address
    function automatic logic [29:0] word_idx(input logic [31:0] addr);
        word_idx = addr[31:2];
    endfunction : word_idx

    // Page selection: breakpoint only mode pages on every program page access,
    // trace capture mode only when the page selector asks for it
    function automatic logic page_select(input logic bp, input logic tc, input logic sel, input logic acc);
        page_select = acc && (bp || (tc && sel));
    endfunction : page_select

    assign bp_on = mode_control[bpq_pkg::MODE_BREAKPOINT_ONLY];
    // Breakpoint only mode takes precedence, so the two never act together
    assign tc_on = mode_control[bpq_pkg::MODE_TRACE_CAPTURE] && !bp_on;
    assign full_on = mode_control[bpq_pkg::MODE_FULL];

    assign addr_phase = hsel && hready && (htrans == bpq_pkg::HTRANS_NONSEQ);
    assign req_idx = word_idx(haddr);

    // Zero wait states, never an error
    assign hreadyout = 1'b1;
    assign hresp = bpq_pkg::HRESP_OKAY;

    // ------------------------------------------------------------
    // Comparator A configuration
    // ------------------------------------------------------------
    assign cmp_a.enable = bp_on || tc_on;
    assign cmp_a.data_mode = 1'b0;
    assign cmp_a.page_sel = page_select(bp_on, tc_on, cmp_a_extended[bpq_pkg::EXT_PAGE_SELECT],
                                        cpu_page_access);
    assign cmp_a.ext = cmp_a_extended[bpq_pkg::EXT_FIELD_MSB:0];
    assign cmp_a.high = cmp_a_high;
    assign cmp_a.low = cmp_a_low;
    // Trace capture ignores the stored first mask bits
    assign cmp_a.mask_hi = debug_control_3[bpq_pkg::C3_FIRST_MASK_HIGH] && !tc_on;
    assign cmp_a.mask_lo = debug_control_3[bpq_pkg::C3_FIRST_MASK_LOW] && !tc_on;
    assign cmp_a.dir_en = debug_control_3[bpq_pkg::C3_A_DIR_ENABLE];
    assign cmp_a.dir_val = debug_control_3[bpq_pkg::C3_A_DIR_VALUE];
    assign a_match = cmp_a.match;

    // ------------------------------------------------------------
    // Comparator B configuration
    // ------------------------------------------------------------
    assign cmp_b.enable = bp_on || tc_on;
    // Full mode turns B into a data comparator in either mode
    assign cmp_b.data_mode = full_on;
    assign cmp_b.page_sel = page_select(bp_on, tc_on, cmp_b_extended[bpq_pkg::EXT_PAGE_SELECT],
                                        cpu_page_access) && !full_on;
    assign cmp_b.ext = cmp_b_extended[bpq_pkg::EXT_FIELD_MSB:0];
    assign cmp_b.high = cmp_b_high;
    assign cmp_b.low = cmp_b_low;
    assign cmp_b.mask_hi = debug_control_3[bpq_pkg::C3_SECOND_MASK_HIGH];
    assign cmp_b.mask_lo = debug_control_3[bpq_pkg::C3_SECOND_MASK_LOW];
    // Direction of B has no say in full mode
    assign cmp_b.dir_en = debug_control_3[bpq_pkg::C3_B_DIR_ENABLE] && !full_on;
    assign cmp_b.dir_val = debug_control_3[bpq_pkg::C3_B_DIR_VALUE];
    assign b_match = cmp_b.match;

    // ------------------------------------------------------------
    // Match units
    // ------------------------------------------------------------
    bpq_match u_match_a (
        .cmp(cmp_a),
        .cpu_addr(cpu_addr),
        .cpu_data(cpu_data),
        .program_page_index(program_page_index),
        .cpu_read(cpu_read),
        .cpu_valid(cpu_valid)
    );

    // B shares the bus
    bpq_match u_match_b (
        .cmp(cmp_b),
        .cpu_addr(cpu_addr),
        .cpu_data(cpu_data),
        .program_page_index(program_page_index),
        .cpu_read(cpu_read),
        .cpu_valid(cpu_valid)
    );

    // ------------------------------------------------------------
    // Register file and bus next state
    // ------------------------------------------------------------
    always_comb begin
        next_debug_control_3 = debug_control_3;
        next_cmp_a_extended = cmp_a_extended;
        next_cmp_a_high = cmp_a_high;
        next_cmp_a_low = cmp_a_low;
        next_cmp_b_extended = cmp_b_extended;
        next_cmp_b_high = cmp_b_high;
        next_cmp_b_low = cmp_b_low;
        next_mode_control = mode_control;
        next_match_status = match_status;
        next_wr_pend = addr_phase && hwrite;
        next_wr_idx = addr_phase ? req_idx : wr_idx;
        next_hrdata = bpq_pkg::RST_WORD;
        // Data phase of a write: only the low byte lane is held
        if (wr_pend) begin
            case (wr_idx)
                bpq_pkg::IDX_DEBUG_CONTROL_3: next_debug_control_3 = hwdata[7:0];
                bpq_pkg::IDX_CMP_A_EXTENDED: next_cmp_a_extended = hwdata[7:0];
                bpq_pkg::IDX_CMP_A_HIGH: next_cmp_a_high = hwdata[7:0];
                bpq_pkg::IDX_CMP_A_LOW: next_cmp_a_low = hwdata[7:0];
                bpq_pkg::IDX_CMP_B_EXTENDED: next_cmp_b_extended = hwdata[7:0];
                bpq_pkg::IDX_CMP_B_HIGH: next_cmp_b_high = hwdata[7:0];
                bpq_pkg::IDX_CMP_B_LOW: next_cmp_b_low = hwdata[7:0];
                bpq_pkg::IDX_MODE_CONTROL: next_mode_control = hwdata[7:0];
                // Write one to clear sticky hits
                bpq_pkg::IDX_MATCH_STATUS: next_match_status = match_status & ~hwdata[7:0];
                default: next_match_status = match_status;
            endcase
        end

        // Hits land after the clear, so a hit in the clearing cycle survives
        next_match_status[bpq_pkg::STAT_HIT_A] = next_match_status[bpq_pkg::STAT_HIT_A] || next_break_a;
        next_match_status[bpq_pkg::STAT_HIT_B] = next_match_status[bpq_pkg::STAT_HIT_B] || next_break_b;
        next_match_status[bpq_pkg::STAT_HIT_BREAK] = next_match_status[bpq_pkg::STAT_HIT_BREAK]
                                                     || next_break_req;

        // Live bits simply follow the comparators
        next_match_status[bpq_pkg::STAT_LIVE_A] = next_break_a;
        next_match_status[bpq_pkg::STAT_LIVE_B] = next_break_b;

        // Read data from next values, except match status, so a write just before is already seen
        if (addr_phase && !hwrite) begin
            case (req_idx)
                bpq_pkg::IDX_DEBUG_CONTROL_3: next_hrdata[7:0] = next_debug_control_3;
                bpq_pkg::IDX_CMP_A_EXTENDED: next_hrdata[7:0] = next_cmp_a_extended;
                bpq_pkg::IDX_CMP_A_HIGH: next_hrdata[7:0] = next_cmp_a_high;
                bpq_pkg::IDX_CMP_A_LOW: next_hrdata[7:0] = next_cmp_a_low;
                bpq_pkg::IDX_CMP_B_EXTENDED: next_hrdata[7:0] = next_cmp_b_extended;
                bpq_pkg::IDX_CMP_B_HIGH: next_hrdata[7:0] = next_cmp_b_high;
                bpq_pkg::IDX_CMP_B_LOW: next_hrdata[7:0] = next_cmp_b_low;
                bpq_pkg::IDX_MODE_CONTROL: next_hrdata[7:0] = next_mode_control;
                bpq_pkg::IDX_MATCH_STATUS: next_hrdata[7:0] = match_status;
                // Unmapped words read as zero
                default: next_hrdata = bpq_pkg::RST_WORD;
            endcase
        end
    end

    // Register file and bus state
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            debug_control_3 <= bpq_pkg::RST_BYTE;
            cmp_a_extended <= bpq_pkg::RST_BYTE;
            cmp_a_high <= bpq_pkg::RST_BYTE;
            cmp_a_low <= bpq_pkg::RST_BYTE;
            cmp_b_extended <= bpq_pkg::RST_BYTE;
            cmp_b_high <= bpq_pkg::RST_BYTE;
            cmp_b_low <= bpq_pkg::RST_BYTE;
            mode_control <= bpq_pkg::RST_BYTE;
            match_status <= bpq_pkg::RST_BYTE;
            wr_pend <= 1'b0;
            wr_idx <= 30'h00000000;
            hrdata <= bpq_pkg::RST_WORD;
        end else begin
            debug_control_3 <= next_debug_control_3;
            cmp_a_extended <= next_cmp_a_extended;
            cmp_a_high <= next_cmp_a_high;
            cmp_a_low <= next_cmp_a_low;
            cmp_b_extended <= next_cmp_b_extended;
            cmp_b_high <= next_cmp_b_high;
            cmp_b_low <= next_cmp_b_low;
            mode_control <= next_mode_control;
            match_status <= next_match_status;
            wr_pend <= next_wr_pend;
            wr_idx <= next_wr_idx;
            hrdata <= next_hrdata;
        end
    end

    // ------------------------------------------------------------
    // Break decision
    // ------------------------------------------------------------
    always_comb begin
        // Straight through
        next_break_a = a_match;
        next_break_b = b_match;

        if (full_on) begin
            // Full mode: one break when address and data agree together
            next_break_req = a_match && b_match;
        end else begin
            // Dual mode: either address comparator breaks
            next_break_req = a_match || b_match;
        end
    end

    // Break outputs are registered, one cycle after the bus cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            break_a <= 1'b0;
            break_b <= 1'b0;
            break_req <= 1'b0;
        end else begin
            break_a <= next_break_a;
            break_b <= next_break_b;
            break_req <= next_break_req;
        end
    end
endmodule : bpq_top

// *** verification/bpq_cpu_model.sv ***
// Behavioural CPU core bus that presents cycles and collects break requests
`timescale 1ns/1ps
module bpq_cpu_model (
    input wire logic ref_clk,
    input wire logic break_a,
    input wire logic break_b,
    input wire logic break_req,
    output logic [15:0] cpu_addr,
    output logic [15:0] cpu_data,
    output logic [5:0] program_page_index,
    output logic cpu_page_access,
    output logic cpu_read,
    output logic cpu_valid
);
    // Bus idle from time zero
    initial {cpu_addr, cpu_data, program_page_index, cpu_page_access, cpu_read, cpu_valid} = 40'h0000000000;
    // Plain cycles only, never tagged fetches, so direction is never asked of a tag
    task automatic cycle(input logic [31:0] ad, input logic [5:0] pg, input logic [1:0] pr, output logic [2:0] brk);
        {cpu_addr, cpu_data, program_page_index, cpu_page_access, cpu_read} <= {ad, pg, pr};
        cpu_valid <= 1'b1;
        @(posedge ref_clk);
        // Invalid cycle shows inverted lines, so stale values cannot match by luck
        {cpu_addr, cpu_data, program_page_index, cpu_page_access, cpu_read} <= ~{ad, pg, pr};
        cpu_valid <= 1'b0;
        @(negedge ref_clk);
        brk = {break_a, break_b, break_req};
        @(posedge ref_clk);
    endtask : cycle
endmodule : bpq_cpu_model

// *** verification/bpq_top_props.sv ***
// Checker for bus and break-output relations of the breakpoint qualifier
`timescale 1ns/1ps
module bpq_top_props (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic cpu_valid,
    input wire logic break_a,
    input wire logic break_b,
    input wire logic break_req
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    // Idle CPU cycles: nothing to compare, so nothing may break
    sequence s_idle; !cpu_valid; endsequence
    sequence s_idle2; s_idle ##1 s_idle; endsequence
    property p_ready; hreadyout == 1'b1; endproperty
    property p_okay; hresp == bpq_pkg::HRESP_OKAY; endproperty
    property p_rd_upper; hrdata[31:8] == 24'h000000; endproperty
    property p_a_cause; s_idle |=> !break_a; endproperty
    property p_b_cause; s_idle |=> !break_b; endproperty
    property p_req_src; break_req |-> (break_a || break_b); endproperty
    property p_req_both; (break_a && break_b) |-> break_req; endproperty
    property p_quiet; s_idle2 |-> !break_req ##1 !break_req; endproperty
    a_ready: assert property (p_ready) else $error("hreadyout dropped");
    a_okay: assert property (p_okay) else $error("hresp not okay");
    a_rd_upper: assert property (p_rd_upper) else $error("hrdata upper bits set");
    a_a_cause: assert property (p_a_cause) else $error("break_a without cpu cycle");
    a_b_cause: assert property (p_b_cause) else $error("break_b without cpu cycle");
    a_req_src: assert property (p_req_src) else $error("break_req without comparator");
    a_req_both: assert property (p_req_both) else $error("break_req missing");
    a_quiet: assert property (p_quiet) else $error("break_req while idle");
endmodule : bpq_top_props
bind bpq_top bpq_top_props i_props (.ref_clk(ref_clk), .arst_n(arst_n), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cpu_valid(cpu_valid), .break_a(break_a), .break_b(break_b), .break_req(break_req));

// *** verification/tb_breakpoint_mask_rw_qualifier.sv ***
// Self-checking bench of the breakpoint mask and direction qualifier
`timescale 1ns/1ps
module tb_breakpoint_mask_rw_qualifier;
    logic ref_clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000, hrdata;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, cpu_page_access, cpu_read, cpu_valid, break_a, break_b, break_req;
    logic [15:0] cpu_addr, cpu_data;
    logic [5:0] program_page_index;
    int bad_count = 0, comparisons = 0;
    // Comparator sets {a_ext, a_high, a_low, b_ext, b_high, b_low}; the idle one sits out of reach
    localparam logic [47:0] RA = 48'h0512343FFFFF;
    localparam logic [47:0] RB = 48'h3FFFFF051234;
    localparam logic [47:0] RF = 48'h0512343FABCD;
    always #4 ref_clk = ~ref_clk;
    bpq_top i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cpu_addr(cpu_addr), .cpu_data(cpu_data),
        .program_page_index(program_page_index), .cpu_page_access(cpu_page_access), .cpu_read(cpu_read),
        .cpu_valid(cpu_valid), .break_a(break_a), .break_b(break_b), .break_req(break_req));
    bpq_cpu_model i_cpu (.ref_clk(ref_clk), .break_a(break_a), .break_b(break_b), .break_req(break_req),
        .cpu_addr(cpu_addr), .cpu_data(cpu_data), .program_page_index(program_page_index),
        .cpu_page_access(cpu_page_access), .cpu_read(cpu_read), .cpu_valid(cpu_valid));
    // Single word transfer; entered right after a rising edge, returns at one
    task automatic ahb(input logic w, input logic [29:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        logic rdy;
        {hsel, haddr, htrans, hwrite} <= {1'b1, idx, 2'h0, bpq_pkg::HTRANS_NONSEQ, w};
        for (int ph = 0; ph < 2; ph++) begin
            do begin
                @(negedge ref_clk);
                rdy = hreadyout;
                rd = hrdata;
                @(posedge ref_clk);
            end while (rdy !== 1'b1);
            if (ph == 0) {htrans, hwdata} <= {2'h0, wd};
        end
    endtask : ahb
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            bad_count++;
            $display("Error at %0t ns: got %h, expected %h", $time, got, want);
        end
    endtask : chk
    // Load mode, masks and comparators, present one cycle, judge {break_a, break_b, break_req}
    task automatic probe(input logic [7:0] mode, input logic [7:0] c3, input logic [47:0] regs,
                         input logic [31:0] ad, input logic [5:0] pg, input logic [1:0] pr, input logic [2:0] exp);
        logic [31:0] rd;
        logic [2:0] brk;
        ahb(1'b1, bpq_pkg::IDX_MODE_CONTROL, {24'h000000, mode}, rd);
        ahb(1'b1, bpq_pkg::IDX_DEBUG_CONTROL_3, {24'h000000, c3}, rd);
        for (int i = 0; i < 6; i++) begin
            ahb(1'b1, bpq_pkg::IDX_CMP_A_EXTENDED + 30'(i), {24'h000000, regs[47 - 8 * i -: 8]}, rd);
        end
        i_cpu.cycle(ad, pg, pr, brk);
        chk({29'h00000000, brk}, {29'h00000000, exp});
    endtask : probe
    task automatic t_regs;
        logic [31:0] rd;
        ahb(1'b0, bpq_pkg::IDX_DEBUG_CONTROL_3, 32'h00000000, rd);
        chk(rd, bpq_pkg::RST_WORD);
        // Upper write bits are dropped, the next read sees the new byte
        ahb(1'b1, bpq_pkg::IDX_DEBUG_CONTROL_3, 32'hFFFFFFA5, rd);
        ahb(1'b0, bpq_pkg::IDX_DEBUG_CONTROL_3, 32'h00000000, rd);
        chk(rd, 32'h000000A5);
        // Unmapped place swallows writes and reads zero
        ahb(1'b1, 30'h00000040, 32'h000000FF, rd);
        ahb(1'b0, 30'h00000040, 32'h00000000, rd);
        chk(rd, 32'h00000000);
        $display("test regs done");
    endtask : t_regs
    task automatic t_first;
        probe(8'h01, 8'h00, RA, 32'h12340000, 6'h06, 2'h2, 3'h0);
        probe(8'h01, 8'h00, RA, 32'h52340000, 6'h05, 2'h2, 3'h5);
        probe(8'h01, 8'h00, RA, 32'h12340000, 6'h06, 2'h0, 3'h5);
        probe(8'h01, 8'h00, RA, 32'h52340000, 6'h05, 2'h0, 3'h0);
        probe(8'h01, 8'h40, RA, 32'h12FF0000, 6'h05, 2'h0, 3'h5);
        probe(8'h01, 8'h80, RA, 32'h12990000, 6'h05, 2'h0, 3'h0);
        probe(8'h01, 8'hC0, RA, 32'h77770000, 6'h05, 2'h2, 3'h5);
        probe(8'h01, 8'hC0, RA, 32'h77770000, 6'h04, 2'h2, 3'h0);
        probe(8'h00, 8'h00, RA, 32'h12340000, 6'h06, 2'h0, 3'h0);
        // Exact breakpoints in trace capture: stored first masks have no effect
        probe(8'h02, 8'h40, RA, 32'h12FF0000, 6'h05, 2'h0, 3'h0);
        $display("test first comparator done");
    endtask : t_first
    task automatic t_second;
        probe(8'h01, 8'h30, RB, 32'h77770000, 6'h05, 2'h2, 3'h3);
        probe(8'h01, 8'h20, RB, 32'h12990000, 6'h06, 2'h0, 3'h0);
        probe(8'h01, 8'h02, RB, 32'h12340000, 6'h06, 2'h1, 3'h0);
        probe(8'h01, 8'h08, RA, 32'h12340000, 6'h06, 2'h1, 3'h0);
        probe(8'h01, 8'h0C, RA, 32'h12340000, 6'h06, 2'h1, 3'h5);
        probe(8'h01, 8'h04, RA, 32'h12340000, 6'h06, 2'h0, 3'h5);
        $display("test second comparator and direction done");
    endtask : t_second
    task automatic t_full;
        logic [31:0] rd;
        probe(8'h05, 8'h00, RF, 32'h1234ABCD, 6'h06, 2'h0, 3'h7);
        probe(8'h05, 8'h10, RF, 32'h1234AB00, 6'h06, 2'h0, 3'h7);
        probe(8'h05, 8'h20, RF, 32'h1234ABCC, 6'h06, 2'h0, 3'h4);
        probe(8'h05, 8'h30, RF, 32'h12340000, 6'h06, 2'h0, 3'h7);
        probe(8'h05, 8'h03, RF, 32'h1234ABCD, 6'h06, 2'h0, 3'h7);
        probe(8'h06, 8'h20, RF, 32'h123400CD, 6'h06, 2'h0, 3'h7);
        // Sticky hits stay, live bits idle
        ahb(1'b0, bpq_pkg::IDX_MATCH_STATUS, 32'h00000000, rd);
        chk(rd, 32'h00000007);
        $display("test full mode done");
    endtask : t_full
    task automatic give_verdict;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_first();
        t_second();
        t_full();
        give_verdict();
    end
    // Tests need about four hundred cycles; a generous margin cuts a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        give_verdict();
    end
endmodule : tb_breakpoint_mask_rw_qualifier
